// ---- dtc_timer_top.v ----
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "dtc_defines.vh"

module dtc_timer_top (
    input  wire        clk,
    input  wire        nrst,
    input  wire [9:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output wire [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire        t0_event_pin,
    input  wire        t1_event_pin,
    input  wire        ext_irq0_pin,
    input  wire        ext_irq1_pin,
    input  wire        t0_isr_ack,
    input  wire        t1_isr_ack,
    output wire        t0_overflow_out,
    output wire        t1_overflow_out,
    output wire        irq
);

    function sel;
        input [7:0] idx;
        input [7:0] reg_idx;
        begin
            sel = (idx == reg_idx);
        end
    endfunction

    // Returns {overflow, high, low} after one increment
    function [16:0] cnt_step;
        input [1:0] mode;
        input [7:0] lo;
        input [7:0] hi;
        reg   [13:0] s13;
        reg   [16:0] s16;
        begin
            s13 = {1'b0, hi, lo[4:0]} + 14'd1;
            s16 = {1'b0, hi, lo} + 17'd1;
            case (mode)
                `DTC_MODE_13BIT: begin
                    cnt_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
                end
                `DTC_MODE_16BIT: begin
                    cnt_step = s16;
                end
                `DTC_MODE_RELOAD: begin
                    if (lo == 8'hFF)
                        cnt_step = {1'b1, hi, hi};
                    else
                        cnt_step = {1'b0, hi, lo + 8'h01};
                end
                default: begin
                    cnt_step = {1'b0, hi, lo};
                end
            endcase
        end
    endfunction

    reg        ack_q;
    reg [7:0]  rdata_q;
    reg [7:0]  rdata_d;
    reg        t0_run_q;
    reg        t1_run_q;
    reg        t0_overflow_flag_q;
    reg        t1_overflow_flag_q;
    reg [7:0]  tmode_q;
    reg [7:0]  rate_q;
    reg [7:0]  t0_low_q;
    reg [7:0]  t0_high_q;
    reg [7:0]  t1_low_q;
    reg [7:0]  t1_high_q;
    reg [1:0]  irq_stat_q;
    reg [1:0]  irq_mask_q;
    reg [1:0]  ev_prev_q;
    reg        t0_out_q;
    reg        t1_out_q;

    wire [3:0] pins_s;
    wire       tick_fast;
    wire       tick_slow;

    dtc_sync #(
        .W(4)
    ) u_sync (
        .clk      (clk),
        .nrst     (nrst),
        .pin_in   ({ext_irq1_pin, ext_irq0_pin, t1_event_pin, t0_event_pin}),
        .pin_sync (pins_s)
    );

    dtc_prescale u_prescale (
        .clk       (clk),
        .nrst      (nrst),
        .tick_fast (tick_fast),
        .tick_slow (tick_slow)
    );

    // Register bus: one wait state, read data registered
    wire       req       = avs_read | avs_write;
    wire [7:0] idx       = avs_address[9:2];
    wire [7:0] wd        = avs_writedata[7:0];
    wire       wr_go     = avs_write & ack_q & avs_byteenable[0];
    wire       wr_tctrl  = wr_go & sel(idx, `DTC_IDX_TCTRL);
    wire       wr_tmode  = wr_go & sel(idx, `DTC_IDX_TMODE);
    wire       wr_rate   = wr_go & sel(idx, `DTC_IDX_RATE);
    wire       wr_t0_lo  = wr_go & sel(idx, `DTC_IDX_T0_LOW);
    wire       wr_t0_hi  = wr_go & sel(idx, `DTC_IDX_T0_HIGH);
    wire       wr_t1_lo  = wr_go & sel(idx, `DTC_IDX_T1_LOW);
    wire       wr_t1_hi  = wr_go & sel(idx, `DTC_IDX_T1_HIGH);
    wire       wr_istat  = wr_go & sel(idx, `DTC_IDX_IRQ_STAT);
    wire       wr_imask  = wr_go & sel(idx, `DTC_IDX_IRQ_MASK);
    wire       t0_wr     = wr_t0_lo | wr_t0_hi;
    wire       t1_wr     = wr_t1_lo | wr_t1_hi;

    assign avs_waitrequest = req & ~ack_q;
    assign avs_readdata    = {24'h00_0000, rdata_q};

    // Falling edges on the synchronised count pins
    wire [1:0] ev_fall = ev_prev_q & ~pins_s[1:0];

    // Timer 0 controls
    wire [1:0] t0_mode  = tmode_q[1:0];
    wire       t0_gate  = tmode_q[`DTC_T0_GATE_BIT];
    wire       t0_src   = tmode_q[`DTC_T0_SRC_BIT];
    wire       t0_core  = rate_q[`DTC_T0_RATE_BIT] ? tick_fast : tick_slow;
    wire       t0_tick  = t0_src ? ev_fall[0] : t0_core;
    wire       t0_split = (t0_mode == `DTC_MODE_SPLIT);
    wire       t0_en    = t0_run_q & (~t0_gate | pins_s[2]) & t0_tick;

    // Timer 1 controls
    wire [1:0] t1_mode  = tmode_q[5:4];
    wire       t1_gate  = tmode_q[`DTC_T1_GATE_BIT];
    wire       t1_src   = tmode_q[`DTC_T1_SRC_BIT];
    wire       t1_core  = rate_q[`DTC_T1_RATE_BIT] ? tick_fast : tick_slow;
    wire       t1_tick  = t1_src ? ev_fall[1] : t1_core;
    wire       t1_stop  = (t1_mode == `DTC_MODE_SPLIT);
    // Split timer 0 owns the timer 1 run bit; timer 1 then runs on its mode and gate alone
    wire       t1_runok = t0_split | t1_run_q;
    wire       t1_en    = t1_runok & (~t1_gate | pins_s[3]) & t1_tick & ~t1_stop;

    wire [16:0] t0_step = cnt_step(t0_mode, t0_low_q, t0_high_q);
    wire [16:0] t1_step = cnt_step(t1_mode, t1_low_q, t1_high_q);
    wire [8:0]  tl0_inc = {1'b0, t0_low_q} + 9'd1;
    wire [8:0]  th0_inc = {1'b0, t0_high_q} + 9'd1;

    // Split high byte: core clock only, timer 1 run bit
    wire th0_en  = t0_split & t1_run_q & t0_core;

    // Writes suppress the timer's increment and overflow that cycle
    wire t0_ovf  = t0_en & ~t0_wr & (t0_split ? tl0_inc[8] : t0_step[16]);
    wire th0_ovf = th0_en & ~t0_wr & th0_inc[8];
    wire t1_ovf  = t1_en & ~t1_wr & t1_step[16];
    wire tf1_set = th0_ovf | (t1_ovf & ~t0_split);

    // Read data mux
    always @* begin
        rdata_d = 8'h00;
        case (idx)
            `DTC_IDX_TCTRL: begin
                rdata_d = {t1_overflow_flag_q, t1_run_q, t0_overflow_flag_q, t0_run_q, 4'h0};
            end
            `DTC_IDX_TMODE: begin
                rdata_d = tmode_q;
            end
            `DTC_IDX_T0_LOW: begin
                rdata_d = t0_low_q;
            end
            `DTC_IDX_T1_LOW: begin
                rdata_d = t1_low_q;
            end
            `DTC_IDX_T0_HIGH: begin
                rdata_d = t0_high_q;
            end
            `DTC_IDX_T1_HIGH: begin
                rdata_d = t1_high_q;
            end
            `DTC_IDX_RATE: begin
                rdata_d = rate_q;
            end
            `DTC_IDX_IRQ_STAT: begin
                rdata_d = {6'h00, irq_stat_q};
            end
            `DTC_IDX_IRQ_MASK: begin
                rdata_d = {6'h00, irq_mask_q};
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    // Bus handshake and configuration
    always @(posedge clk) begin
        if (!nrst) begin
            ack_q      <= 1'b0;
            rdata_q    <= 8'h00;
            tmode_q    <= `DTC_RST_TMODE;
            rate_q     <= `DTC_RST_RATE;
            irq_mask_q <= 2'b00;
            ev_prev_q  <= 2'b00;
        end else begin
            ack_q     <= req & ~ack_q;
            ev_prev_q <= pins_s[1:0];
            if (avs_read & ~ack_q)
                rdata_q <= rdata_d;
            if (wr_tmode)
                tmode_q <= wd;
            if (wr_rate)
                rate_q <= wd;
            if (wr_imask)
                irq_mask_q <= wd[1:0];
        end
    end

    // Run bits, overflow flags and output pulses
    always @(posedge clk) begin
        if (!nrst) begin
            t0_run_q           <= 1'b0;
            t1_run_q           <= 1'b0;
            t0_overflow_flag_q <= 1'b0;
            t1_overflow_flag_q <= 1'b0;
            t0_out_q           <= 1'b0;
            t1_out_q           <= 1'b0;
            irq_stat_q         <= 2'b00;
        end else begin
            t0_out_q <= t0_ovf;
            t1_out_q <= t1_ovf | th0_ovf;
            if (wr_tctrl) begin
                t0_run_q <= wd[`DTC_TR0_BIT];
                t1_run_q <= wd[`DTC_TR1_BIT];
            end
            // Hardware set wins over software or vector clear
            if (t0_ovf)
                t0_overflow_flag_q <= 1'b1;
            else if (t0_isr_ack)
                t0_overflow_flag_q <= 1'b0;
            else if (wr_tctrl)
                t0_overflow_flag_q <= wd[`DTC_TF0_BIT];
            if (tf1_set)
                t1_overflow_flag_q <= 1'b1;
            else if (t1_isr_ack)
                t1_overflow_flag_q <= 1'b0;
            else if (wr_tctrl)
                t1_overflow_flag_q <= wd[`DTC_TF1_BIT];
            irq_stat_q <= (irq_stat_q & ~({2{wr_istat}} & wd[1:0])) | {tf1_set, t0_ovf};
        end
    end

    // Timer 0 count
    always @(posedge clk) begin
        if (!nrst) begin
            t0_low_q  <= `DTC_RST_COUNT;
            t0_high_q <= `DTC_RST_COUNT;
        end else if (t0_wr) begin
            if (wr_t0_lo)
                t0_low_q <= wd;
            if (wr_t0_hi)
                t0_high_q <= wd;
        end else if (t0_split) begin
            if (t0_en)
                t0_low_q <= tl0_inc[7:0];
            if (th0_en)
                t0_high_q <= th0_inc[7:0];
        end else if (t0_en) begin
            t0_low_q  <= t0_step[7:0];
            t0_high_q <= t0_step[15:8];
        end
    end

    // Timer 1 count; mode 11 clears t1_en so the count holds
    always @(posedge clk) begin
        if (!nrst) begin
            t1_low_q  <= `DTC_RST_COUNT;
            t1_high_q <= `DTC_RST_COUNT;
        end else if (t1_wr) begin
            if (wr_t1_lo)
                t1_low_q <= wd;
            if (wr_t1_hi)
                t1_high_q <= wd;
        end else if (t1_en) begin
            t1_low_q  <= t1_step[7:0];
            t1_high_q <= t1_step[15:8];
        end
    end

    assign t0_overflow_out = t0_out_q;
    assign t1_overflow_out = t1_out_q;
    assign irq             = |(irq_stat_q & irq_mask_q);

endmodule // dtc_timer_top

// ---- dtc_defines.vh ----
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// Register indexes; byte address is four times the index
`define DTC_IDX_TCTRL     8'h88
`define DTC_IDX_TMODE     8'h89
`define DTC_IDX_T0_LOW    8'h8A
`define DTC_IDX_T1_LOW    8'h8B
`define DTC_IDX_T0_HIGH   8'h8C
`define DTC_IDX_T1_HIGH   8'h8D
`define DTC_IDX_RATE      8'h8E
`define DTC_IDX_IRQ_STAT  8'h40
`define DTC_IDX_IRQ_MASK  8'h41

// timer_ctrl_flags fields
`define DTC_TF1_BIT       7
`define DTC_TR1_BIT       6
`define DTC_TF0_BIT       5
`define DTC_TR0_BIT       4

// timer_mode_select fields, timer 1 nibble is 7:4, timer 0 nibble 3:0
`define DTC_T1_GATE_BIT   7
`define DTC_T1_SRC_BIT    6
`define DTC_T0_GATE_BIT   3
`define DTC_T0_SRC_BIT    2

// clock_rate_ctrl fields
`define DTC_T1_RATE_BIT   4
`define DTC_T0_RATE_BIT   3

// Mode codes
`define DTC_MODE_13BIT    2'b00
`define DTC_MODE_16BIT    2'b01
`define DTC_MODE_RELOAD   2'b10
`define DTC_MODE_SPLIT    2'b11

// Reset values
`define DTC_RST_TCTRL     8'h00
`define DTC_RST_TMODE     8'h00
`define DTC_RST_COUNT     8'h00
`define DTC_RST_RATE      8'h01

// Core clock dividers
`define DTC_DIV_FAST      4'd4
`define DTC_DIV_SLOW      4'd12

`endif

// ---- dtc_sync.v ----
`timescale 1ns/1ps
module dtc_sync #(
    parameter W = 4
) (
    input  wire         clk,
    input  wire         nrst,
    input  wire [W-1:0] pin_in,
    output wire [W-1:0] pin_sync
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // First stage feeds only the second stage
    always @(posedge clk) begin
        if (!nrst) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign pin_sync = sync_q;
endmodule // dtc_sync

// ---- dtc_prescale.v ----
`timescale 1ns/1ps
`include "dtc_defines.vh"
module dtc_prescale (
    input  wire clk,
    input  wire nrst,
    output wire tick_fast,
    output wire tick_slow
);
    reg [3:0] slow_cnt_q;
    reg [3:0] fast_cnt_q;
    reg       fast_q;
    reg       slow_q;

    always @(posedge clk) begin
        if (!nrst) begin
            slow_cnt_q <= 4'h0;
            fast_cnt_q <= 4'h0;
            fast_q     <= 1'b0;
            slow_q     <= 1'b0;
        end else begin
            fast_q <= (fast_cnt_q == `DTC_DIV_FAST - 4'd1);
            slow_q <= (slow_cnt_q == `DTC_DIV_SLOW - 4'd1);
            if (fast_cnt_q == `DTC_DIV_FAST - 4'd1)
                fast_cnt_q <= 4'h0;
            else
                fast_cnt_q <= fast_cnt_q + 4'd1;
            if (slow_cnt_q == `DTC_DIV_SLOW - 4'd1)
                slow_cnt_q <= 4'h0;
            else
                slow_cnt_q <= slow_cnt_q + 4'd1;
        end
    end

    assign tick_fast = fast_q;
    assign tick_slow = slow_q;
endmodule // dtc_prescale

// ---- dtc_timer_top_monitor.sv ----
`timescale 1ns/1ps
module dtc_timer_top_monitor (
    input wire        clk,
    input wire        nrst,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire        t0_overflow_out,
    input wire        t1_overflow_out,
    input wire        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held past one wait state");
    AST_WAIT_IDLE: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high while idle");
    AST_WAIT_SET: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("request answered without wait state");
    AST_T0_PULSE: assert property (t0_overflow_out |=> !t0_overflow_out)
        else $error("overflow pulse longer than one clock");
    AST_RDATA_HI: assert property (avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    AST_RDATA_HOLD: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    AST_IRQ_RISE: assert property ($rose(irq) |-> (##[0:1] (t0_overflow_out || t1_overflow_out))
        or $past(avs_write))
        else $error("interrupt rose without overflow or write");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(avs_write))
        else $error("interrupt fell without a write");
endmodule // dtc_timer_top_monitor
bind dtc_timer_top dtc_timer_top_monitor dtc_timer_top_monitor_inst (.clk, .nrst, .avs_read, .avs_write,
    .avs_readdata, .avs_waitrequest, .t0_overflow_out, .t1_overflow_out, .irq);

// ---- dtc_pin_model.sv ----
`timescale 1ns/1ps
module dtc_pin_model (
    input  wire clk,
    input  wire gate0,
    input  wire gate1,
    output reg  t0_event_pin,
    output reg  t1_event_pin,
    output wire ext_irq0_pin,
    output wire ext_irq1_pin
);
    assign ext_irq0_pin = gate0;
    assign ext_irq1_pin = gate1;
    initial begin
        t0_event_pin = 1'b1;
        t1_event_pin = 1'b1;
    end
    // Three clocks per level so the synchroniser never misses an edge
    task pulses(input s, input integer n);
        integer k;
        for (k = 0; k < n; k = k + 1) begin
            repeat (3) @(posedge clk);
            if (s) t1_event_pin <= 1'b0; else t0_event_pin <= 1'b0;
            repeat (3) @(posedge clk);
            if (s) t1_event_pin <= 1'b1; else t0_event_pin <= 1'b1;
        end
    endtask
endmodule // dtc_pin_model

// ---- dtc_timer_top_test.sv ----
`timescale 1ns/1ps
module dtc_timer_top_test;
    reg         clk = 0, nrst = 0, read_q = 0, write_q = 0, ack0_q = 0, gate0_q = 1;
    reg  [9:0]  addr_q = 0;
    reg  [31:0] wdata_q = 0;
    wire [31:0] rdata;
    wire        wait_w, o0, o1, irq, p0, p1, g0, g1;
    integer     errors = 0, compares = 0, cyc = 0, seed = 32'he4cd, n, i, m, c0 = 0, st;
    reg  [7:0]  v, r, vals [0:6];
    initial begin
        forever #2.5 clk = ~clk;
    end
    dtc_timer_top dtc_timer_top_inst (.clk(clk), .nrst(nrst), .avs_address(addr_q), .avs_read(read_q),
        .avs_write(write_q), .avs_writedata(wdata_q), .avs_byteenable(4'h1), .avs_readdata(rdata),
        .avs_waitrequest(wait_w), .t0_event_pin(p0), .t1_event_pin(p1), .ext_irq0_pin(g0),
        .ext_irq1_pin(g1), .t0_isr_ack(ack0_q), .t1_isr_ack(1'b0), .t0_overflow_out(o0),
        .t1_overflow_out(o1), .irq(irq));
    dtc_pin_model dtc_pin_model_inst (.clk(clk), .gate0(gate0_q), .gate1(1'b1), .t0_event_pin(p0),
        .t1_event_pin(p1), .ext_irq0_pin(g0), .ext_irq1_pin(g1));
    function integer per(input [7:0] rl, input f);
        per = (256 - rl) * (f ? 4 : 12);
    endfunction
    task finish_test;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task bus(input w, input [7:0] idx, input [7:0] d, output [7:0] q);
        @(posedge clk);
        addr_q <= {idx, 2'b00};
        wdata_q <= {24'h0, d};
        read_q <= !w;
        write_q <= w;
        @(posedge clk);
        while (wait_w !== 1'b0) @(posedge clk);
        q = rdata[7:0];
        read_q <= 0;
        write_q <= 0;
    endtask
    task wr(input [7:0] idx, input [7:0] d);
        bus(1, idx, d, v);
    endtask
    task rd(input [7:0] idx);
        bus(0, idx, 8'h00, v);
    endtask
    task wpulse(input s, input integer lim, output integer c);
        c = 0;
        do begin
            @(negedge clk);
            c = c + 1;
        end while ((s ? o1 : o0) !== 1'b1 && c < lim);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (o0 === 1'b1) c0 <= c0 + 1;
        if (cyc == 60000) begin
            errors = errors + 1;
            finish_test;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1;
        for (i = 0; i < 8; i = i + 1) begin
            rd(i == 7 ? 8'h20 : 8'h88 + i);
            chk("reset", v, i == 6 ? 8'h01 : 8'h00);
        end
        for (i = 1; i < 7; i = i + 1) begin
            vals[i] = $random(seed);
            wr(8'h88 + i, vals[i]);
        end
        repeat (40) @(posedge clk);
        for (i = 1; i < 7; i = i + 1) begin
            rd(8'h88 + i);
            chk("readback", v, vals[i]);
        end
        for (i = 0; i < 2; i = i + 1) begin
            r = 8'hf0 | $random(seed);
            wr(8'h8E, i ? 8'h08 : 8'h00);
            wr(8'h89, 8'h02);
            wr(8'h8C, r);
            wr(8'h8A, r);
            wr(8'h88, 8'h10);
            wpulse(0, 5000, n);
            wpulse(0, 5000, n);
            chk("reload period", n, per(r, i));
        end
        @(posedge clk);
        gate0_q <= 0;
        wr(8'h89, 8'h0A);
        wpulse(0, 600, n);
        chk("gate low", n, 600);
        @(posedge clk);
        gate0_q <= 1;
        wpulse(0, 600, n);
        chk("gate high", n < 600, 1);
        for (m = 0; m < 2; m = m + 1) begin
            wr(8'h88, 8'h00);
            wr(8'h89, m);
            wr(8'h8C, 8'hFF);
            wr(8'h8A, m ? 8'hFC : 8'h1C);
            wr(8'h40, 8'h03);
            wr(8'h41, 8'h00);
            wr(8'h88, 8'h10);
            wpulse(0, 60, n);
            chk("wrap", n < 60, 1);
            rd(8'h8C);
            chk("high after wrap", v, 8'h00);
            rd(8'h88);
            chk("flag set", v & 8'h20, 8'h20);
            chk("masked irq", irq, 0);
            wr(8'h41, 8'h01);
            @(negedge clk);
            chk("irq", irq, 1);
            @(posedge clk) ack0_q <= 1;
            @(posedge clk) ack0_q <= 0;
            rd(8'h88);
            chk("flag clear", v & 8'h20, 8'h00);
            wr(8'h40, 8'h01);
            @(negedge clk);
            chk("irq clear", irq, 0);
        end
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h06);
        wr(8'h8C, 8'hFD);
        wr(8'h8A, 8'hFD);
        wr(8'h88, 8'h10);
        st = c0;
        dtc_pin_model_inst.pulses(0, 6);
        repeat (8) @(posedge clk);
        chk("event overflows", c0 - st, 2);
        v = $random(seed);
        r = v;
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h33);
        wr(8'h8C, 8'hFE);
        wr(8'h8B, r);
        wr(8'h88, 8'h40);
        wpulse(1, 60, n);
        chk("split overflow", n < 60, 1);
        rd(8'h88);
        chk("split flag", v & 8'h80, 8'h80);
        rd(8'h8B);
        chk("t1 held", v, r);
        finish_test;
    end
endmodule // dtc_timer_top_test
